// >>> rtl/ubtpc_core.sv
// Upstream burst timing, inter-burst gap and transmit power control with an AXI4-Lite slave.
//
// Function
// - Advance burst start by the ranging offset.
// - Signed adjustment; negative means transmit later.
// - Apply corrections at one-symbol granularity; the code steps by four units (one 2.56 Msym/s symbol) at every rate.
// - Timing measured against derived mini-slot boundaries.
// - Back-to-back switch unless listed parameter changes.
// - Rate, offset, ranging, modulation need 96 symbols.
// - Parameters change only outside burst energy.
// - Channel change needs 96 symbols plus 100 ms.
// - Power gap 96 symbols plus 5/10 us.
// - Power held constant during a burst.
// - Power 8 to 55/58 dBmV, 1 dB steps.
// - One dB step stays within tolerance.
// - Round finer power steps to nearest.
// - Exact midpoint rounds toward smaller step.
// - Ranging offset unsigned 16 bits, 1/64 tick.
// - Five octave rates set the symbol period.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ubtpc_core
   import ubtpc_pkg::*;
#(
   parameter int unsigned FREQ_CHANGE_CYCLES = FREQ_CHANGE_CYC,
   parameter int unsigned SYM_CYC_FAST = 98
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address, data and response.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Timebase from the downstream timestamp recovery.
   input wire logic minislot_tick,
   input wire logic [15:0] frame_time,
   // Transmitter side.
   output logic burst_start,
   output logic tx_active,
   output ubtpc_cfg_type tx_cfg,
   output logic [7:0] tx_power_dbmv,
   output logic power_settled
);
   logic [15:0] ranging_ff;
   logic [15:0] pending_rng_ff;
   ubtpc_cfg_type cfg_ff;
   ubtpc_cfg_type pending_cfg_ff;
   logic [7:0] power_ff;
   logic [7:0] pending_pwr_ff;
   logic pend_ff;
   logic [15:0] grant_time_ff;
   logic [15:0] grant_len_ff;
   logic grant_armed_ff;
   logic short_gap_ff;
   ubtpc_state_type state_ff;
   logic [15:0] burst_cnt_ff;
   logic [31:0] gap_cnt_ff;
   logic [31:0] settle_cnt_ff;
   logic [31:0] need_cyc;
   logic [31:0] sym_cyc;
   logic [15:0] tx_time;
   logic cfg_diff;
   logic pwr_big;
   logic chg_diff;
   logic grant_hit;
   logic apply_now;
   logic [31:0] base_cyc;
   logic aw_ff, w_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic wr_go, rd_go;

   // Cycles per symbol; each halving of rate doubles it.
   function automatic logic [31:0] sym_cycles(input logic [2:0] sel);
      logic [2:0] s;
      s = (sel > 3'h4) ? 3'h4 : sel;
      return 32'(SYM_CYC_FAST) << (3'h4 - s);
   endfunction

   // Round a quarter-dB step to whole dB, ties toward the smaller magnitude.
   function automatic logic signed [7:0] round_step(input logic signed [7:0] q);
      logic [7:0] mag;
      logic [7:0] whole;
      mag = q[7] ? 8'(-q) : q;
      whole = mag >> PWR_FRAC_BITS;
      if (mag[1:0] > 2'h2)
         whole = whole + 8'h01;
      // A remainder of exactly half stays at the smaller step.
      return q[7] ? 8'(-whole) : whole;
   endfunction

   assign sym_cyc = sym_cycles(cfg_ff.rate_sel);
   // Transmit when the frame time reaches the grant minus the offset, truncated
   // to whole fast symbols so the advance moves in symbol steps.
   assign tx_time = grant_time_ff - {ranging_ff[15:2], 2'b00};
   assign cfg_diff = (pending_cfg_ff != cfg_ff) || (pending_rng_ff != ranging_ff);
   assign chg_diff = cfg_diff || (pending_pwr_ff != power_ff);
   assign pwr_big = (pending_pwr_ff > power_ff + 8'h01) || (power_ff > pending_pwr_ff + 8'h01);

   // Required gap: 96 symbols plus the power or channel extra.
   assign base_cyc = 32'(GAP_SYMBOLS) * sym_cyc;
   always_comb begin
      need_cyc = base_cyc;
      if (pending_cfg_ff.chan_freq != cfg_ff.chan_freq)
         need_cyc = need_cyc + FREQ_CHANGE_CYCLES;
      else if (pending_pwr_ff != power_ff)
         need_cyc = need_cyc + (pwr_big ? PWR_LARGE_CYC : PWR_SMALL_CYC);
   end

   // AXI4-Lite slave: one write and one read in flight.
   assign s_axi_awready = !aw_ff && !s_axi_bvalid;
   assign s_axi_wready = !w_ff && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go = aw_ff && w_ff && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;

   // A change is taken over once the 96-symbol ramp window after a burst has passed;
   // the settle count then covers the power or channel extra. A change with no
   // difference cuts in at once.
   assign apply_now = (state_ff == ST_GAP) && pend_ff && !burst_start
                      && (!chg_diff || gap_cnt_ff >= base_cyc);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
         end
         if (wr_go) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awaddr_ff <= REG_FREQ_CMD && awaddr_ff[1:0] == 2'b00
                         && awaddr_ff != REG_STATUS && awaddr_ff != REG_POWER)
                        ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Pending configuration, written by software while bursts may be in flight.
   always_ff @(posedge aclk) begin
      logic signed [7:0] step;
      logic [8:0] target;
      logic [7:0] pmax;
      step = 8'sh00;
      target = 9'h000;
      pmax = 8'h00;
      if (!aresetn) begin
         pending_cfg_ff <= '0;
         pending_rng_ff <= 16'h0000;
         pending_pwr_ff <= PWR_RESET_DBMV;
         pend_ff <= 1'b0;
         grant_time_ff <= 16'h0000;
         grant_len_ff <= 16'h0000;
         grant_armed_ff <= 1'b0;
      end else begin
         // A slot that passes while the transmitter cannot use it is lost, not retried.
         if (grant_hit)
            grant_armed_ff <= 1'b0;
         // Cleared when taken over, so a write that lands during settling stays pending.
         if (apply_now)
            pend_ff <= 1'b0;
         if (wr_go && (s_axi_wstrb != 4'h0)) begin
            case (awaddr_ff)
               REG_CTRL: begin
                  pending_cfg_ff.rate_sel <= wdata_ff[2:0];
                  pending_cfg_ff.modulation <= ubtpc_mod_type'(wdata_ff[5:4]);
                  pending_cfg_ff.offset_freq <= wdata_ff[31:16];
                  // The 16QAM ceiling is lower, so a held power above it is pulled down.
                  if (wdata_ff[5:4] == MOD_QAM16 && pending_pwr_ff > PWR_MAX_QAM16_DBMV)
                     pending_pwr_ff <= PWR_MAX_QAM16_DBMV;
                  pend_ff <= 1'b1;
               end
               REG_RANGING: begin
                  pending_rng_ff <= wdata_ff[15:0];
                  pend_ff <= 1'b1;
               end
               REG_ADJUST: begin
                  // Signed adjustment; negative delays transmission.
                  pending_rng_ff <= pending_rng_ff + wdata_ff[15:0];
                  pend_ff <= 1'b1;
               end
               REG_POWER_CMD: begin
                  step = round_step(wdata_ff[7:0]);
                  target = {1'b0, pending_pwr_ff} + {step[7], step};
                  pmax = (pending_cfg_ff.modulation == MOD_QAM16) ? PWR_MAX_QAM16_DBMV
                                                                   : PWR_MAX_QPSK_DBMV;
                  if (target[8] || target[7:0] < PWR_MIN_DBMV)
                     pending_pwr_ff <= PWR_MIN_DBMV;
                  else if (target[7:0] > pmax)
                     pending_pwr_ff <= pmax;
                  else
                     pending_pwr_ff <= target[7:0];
                  pend_ff <= 1'b1;
               end
               REG_GRANT: begin
                  grant_time_ff <= wdata_ff[15:0];
                  grant_len_ff <= wdata_ff[31:16];
                  grant_armed_ff <= 1'b1;
               end
               REG_FREQ_CMD: begin
                  pending_cfg_ff.chan_freq <= wdata_ff[15:0];
                  pend_ff <= 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Burst and gap sequencer.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_IDLE;
         burst_cnt_ff <= 16'h0000;
         gap_cnt_ff <= 32'h0000_0000;
         settle_cnt_ff <= 32'h0000_0000;
         short_gap_ff <= 1'b0;
         cfg_ff <= '0;
         ranging_ff <= 16'h0000;
         power_ff <= PWR_RESET_DBMV;
      end else begin
         if (wr_go && awaddr_ff == REG_STATUS)
            short_gap_ff <= 1'b0;
         if (gap_cnt_ff != 32'hFFFF_FFFF)
            gap_cnt_ff <= gap_cnt_ff + 32'h0000_0001;
         case (state_ff)
            ST_IDLE, ST_GAP: begin
               if (burst_start) begin
                  state_ff <= ST_BURST;
                  burst_cnt_ff <= grant_len_ff;
               end else if (apply_now) begin
                  // Only a change with no difference may cut in immediately.
                  if (!chg_diff) begin
                     state_ff <= ST_SETTLE;
                     settle_cnt_ff <= 32'h0000_0000;
                  end else begin
                     cfg_ff <= pending_cfg_ff;
                     ranging_ff <= pending_rng_ff;
                     power_ff <= pending_pwr_ff;
                     state_ff <= ST_SETTLE;
                     settle_cnt_ff <= (pending_cfg_ff.chan_freq != cfg_ff.chan_freq)
                                      ? FREQ_CHANGE_CYCLES
                                      : (pwr_big ? PWR_LARGE_CYC : PWR_SMALL_CYC);
                  end
               end
               // Before the first burst no gap can be measured, so changes wait for one.
            end
            ST_BURST: begin
               // Configuration is frozen through the burst.
               if (minislot_tick) begin
                  if (burst_cnt_ff <= 16'h0001) begin
                     state_ff <= ST_GAP;
                     gap_cnt_ff <= 32'h0000_0000;
                  end else
                     burst_cnt_ff <= burst_cnt_ff - 16'h0001;
               end
            end
            ST_SETTLE: begin
               if (settle_cnt_ff != 32'h0000_0000)
                  settle_cnt_ff <= settle_cnt_ff - 32'h0000_0001;
               else
                  state_ff <= ST_GAP;
               // A grant that lands while settling cannot be served and is flagged.
               if (grant_hit)
                  short_gap_ff <= 1'b1;
            end
            default: state_ff <= ST_IDLE;
         endcase
         // A grant arriving before the required gap elapsed is flagged.
         if (burst_start && state_ff == ST_GAP && pend_ff && chg_diff
             && gap_cnt_ff < need_cyc)
            short_gap_ff <= 1'b1;
      end
   end

   // A burst may not open while a change is still settling.
   assign grant_hit = grant_armed_ff && (frame_time == tx_time) && minislot_tick;
   assign burst_start = grant_hit && (state_ff != ST_SETTLE) && (state_ff != ST_BURST);
   assign tx_active = (state_ff == ST_BURST);
   assign tx_cfg = cfg_ff;
   assign tx_power_dbmv = power_ff;
   assign power_settled = (state_ff != ST_SETTLE);

   // Read path.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case (s_axi_araddr)
            REG_CTRL: s_axi_rdata <= {pending_cfg_ff.offset_freq, 10'h000,
                                     pending_cfg_ff.modulation, 1'b0, pending_cfg_ff.rate_sel};
            REG_RANGING: s_axi_rdata <= {16'h0000, ranging_ff};
            REG_ADJUST: s_axi_rdata <= {16'h0000, pending_rng_ff};
            REG_POWER_CMD: s_axi_rdata <= {24'h00_0000, pending_pwr_ff};
            REG_GRANT: s_axi_rdata <= {grant_len_ff, grant_time_ff};
            REG_STATUS: s_axi_rdata <= {26'h000_0000, short_gap_ff, grant_armed_ff,
                                       pend_ff, tx_active, state_ff};
            REG_POWER: s_axi_rdata <= {24'h00_0000, power_ff};
            REG_FREQ_CMD: s_axi_rdata <= {16'h0000, cfg_ff.chan_freq};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule // ubtpc_core

// >>> rtl/ubtpc_pkg.sv
// Package with constants and carrier types for the upstream burst timing and power control.
package ubtpc_pkg;
   localparam int unsigned CLK_MHZ = 250;
   // Timing constants in their own units, then in clock cycles.
   localparam int unsigned GAP_SYMBOLS = 96;
   localparam int unsigned PWR_SMALL_US = 5;
   localparam int unsigned PWR_LARGE_US = 10;
   localparam int unsigned FREQ_CHANGE_MS = 100;
   localparam int unsigned PWR_SMALL_CYC = PWR_SMALL_US * CLK_MHZ;
   localparam int unsigned PWR_LARGE_CYC = PWR_LARGE_US * CLK_MHZ;
   localparam int unsigned FREQ_CHANGE_CYC = FREQ_CHANGE_MS * 1000 * CLK_MHZ;
   // Ranging unit: 6.25 us / 64 = 97.65625 ns; a 2.56 Msym/s symbol is four units.
   localparam int unsigned UNITS_PER_FAST_SYM = 4;
   // Power range in whole dBmV.
   localparam logic [7:0] PWR_MIN_DBMV = 8'h08;
   localparam logic [7:0] PWR_MAX_QAM16_DBMV = 8'h37;
   localparam logic [7:0] PWR_MAX_QPSK_DBMV = 8'h3A;
   localparam logic [7:0] PWR_RESET_DBMV = 8'h08;
   // Power commands arrive in quarter dB, two fraction bits.
   localparam int unsigned PWR_FRAC_BITS = 2;
   // Register byte offsets.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_RANGING = 8'h04;
   localparam logic [7:0] REG_ADJUST = 8'h08;
   localparam logic [7:0] REG_POWER_CMD = 8'h0C;
   localparam logic [7:0] REG_GRANT = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_POWER = 8'h18;
   localparam logic [7:0] REG_FREQ_CMD = 8'h1C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {MOD_QPSK = 2'h0, MOD_QAM16 = 2'h1} ubtpc_mod_type;

   // Burst configuration that changes only inside a wide enough gap.
   typedef struct packed {
      logic [2:0] rate_sel;
      ubtpc_mod_type modulation;
      logic [15:0] offset_freq;
      logic [15:0] chan_freq;
   } ubtpc_cfg_type;

   // Gap sequencer states, Gray coded along the usual path.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BURST = 2'b01,
      ST_GAP = 2'b11,
      ST_SETTLE = 2'b10
   } ubtpc_state_type;
endpackage

// >>> tb/testbench.sv
// Self-checking bench for the upstream burst timing and power core.
`timescale 1ns/1ps
module testbench
   import ubtpc_pkg::*;
();
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic slow = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic minislot_tick, burst_start, tx_active, power_settled;
   logic [15:0] frame_time, ft_seen;
   ubtpc_cfg_type tx_cfg;
   logic [7:0] tx_power_dbmv;
   int fail_count = 0, checked = 0;
   logic [7:0] pcmd [11] = '{8'h02, 8'h03, 8'h06, 8'hFE, 8'hFD, 8'h7F, 8'h7F, 8'h80, 8'h80,
                             8'h7F, 8'h7F};
   logic [7:0] pexp [11] = '{8'h08, 8'h09, 8'h0A, 8'h0A, 8'h09, 8'h29, 8'h3A, 8'h1A, 8'h08,
                             8'h28, 8'h37};
   ubtpc_core #(.FREQ_CHANGE_CYCLES(200), .SYM_CYC_FAST(2)) u_ubtpc_core (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .minislot_tick, .frame_time, .burst_start, .tx_active,
      .tx_cfg, .tx_power_dbmv, .power_settled
   );
   ubtpc_headend_model u_ubtpc_headend_model (
      .aclk, .aresetn, .slow, .minislot_tick, .frame_time
   );
   always #2 aclk = ~aclk;
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("Compared %0d values, %0d mismatches", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         ad = ad | s_axi_awready;
         wd = wd | s_axi_wready;
         s_axi_awvalid <= !ad;
         s_axi_wvalid <= !wd;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk({62'h0, s_axi_bresp}, {62'h0, er});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m,
                     input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk({32'h0, s_axi_rdata & m}, {32'h0, ed});
      chk({62'h0, s_axi_rresp}, {62'h0, er});
   endtask
   // Selector 0 waits on a burst start, 1 on transmit, 2 on power settled.
   task automatic wait_on(input int sel, input logic lvl);
      logic v;
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         v = sel == 0 ? burst_start : sel == 1 ? tx_active : power_settled;
         ft_seen = frame_time;
         n++;
      end while (v !== lvl && n < 9000);
      chk({63'h0, v}, {63'h0, lvl});
   endtask
   // Grants four ticks at the given lead and checks the advanced start time.
   task automatic burst(input logic [15:0] ahead, input logic [15:0] adv);
      logic [15:0] t;
      t = frame_time + ahead;
      wr(REG_GRANT, {16'h0004, t}, RESP_OKAY);
      wait_on(0, 1'b1);
      chk({48'h0, ft_seen}, {48'h0, t - adv});
      wait_on(1, 1'b0);
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(REG_POWER, 32'h0000_0008, 32'h0000_00FF, RESP_OKAY);
      rd(REG_STATUS, 32'h0000_0000, 32'h0000_003F, RESP_OKAY);
      rd(8'h20, 32'h0000_0000, 32'h0000_0000, RESP_SLVERR);
      rd(8'h02, 32'h0000_0000, 32'h0000_0000, RESP_SLVERR);
      wr(REG_POWER, 32'h0000_0000, RESP_SLVERR);
      wr(8'h24, 32'h0000_0000, RESP_SLVERR);
      for (int i = 0; i < 11; i++) begin
         if (i == 9) wr(REG_CTRL, 32'h0005_0014, RESP_OKAY);
         wr(REG_POWER_CMD, {24'h0, pcmd[i]}, RESP_OKAY);
         rd(REG_POWER_CMD, {24'h0, pexp[i]}, 32'h0000_00FF, RESP_OKAY);
      end
      wr(REG_FREQ_CMD, 32'h0000_1234, RESP_OKAY);
      wr(REG_RANGING, 32'h0000_0106, RESP_OKAY);
      wr(REG_ADJUST, 32'h0000_FFF0, RESP_OKAY);
      rd(REG_ADJUST, 32'h0000_00F6, 32'h0000_FFFF, RESP_OKAY);
      rd(REG_RANGING, 32'h0000_0000, 32'h0000_FFFF, RESP_OKAY);
      rd(REG_STATUS, 32'h0000_0008, 32'h0000_0008, RESP_OKAY);
      burst(16'h0064, 16'h0000);
      wait_on(2, 1'b0);
      wait_on(2, 1'b1);
      chk({56'h0, tx_power_dbmv}, 64'h0000_0000_0000_0037);
      chk({27'h0, tx_cfg}, {27'h0, 3'h4, MOD_QAM16, 16'h0005, 16'h1234});
      rd(REG_RANGING, 32'h0000_00F6, 32'h0000_FFFF, RESP_OKAY);
      // A wide gap first, then a grant far inside the power change need.
      burst(16'h0FA0, 16'h00F4);
      rd(REG_STATUS, 32'h0000_0000, 32'h0000_0020, RESP_OKAY);
      wr(REG_POWER_CMD, 32'h0000_00F8, RESP_OKAY);
      slow <= 1'b1;
      burst(16'h0100, 16'h00F4);
      rd(REG_STATUS, 32'h0000_0020, 32'h0000_0020, RESP_OKAY);
      wait_on(2, 1'b0);
      wait_on(2, 1'b1);
      chk({56'h0, tx_power_dbmv}, 64'h0000_0000_0000_0035);
      complete_run();
   end
   initial begin
      repeat (60000) @(posedge aclk);
      fail_count++;
      complete_run();
   end
endmodule // testbench

// >>> tb/ubtpc_core_chk.sv
// Port checker for the burst timing and power core, bound to every core instance.
`timescale 1ns/1ps
module ubtpc_core_chk
   import ubtpc_pkg::*;
#(
   parameter int unsigned FREQ_CHANGE_CYCLES = FREQ_CHANGE_CYC,
   parameter int unsigned SYM_CYC_FAST = 98
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Timebase and transmitter.
   input wire logic minislot_tick,
   input wire logic burst_start,
   input wire logic tx_active,
   input wire ubtpc_cfg_type tx_cfg,
   input wire logic [7:0] tx_power_dbmv,
   input wire logic power_settled
);
   // A sum of both waits is loose, but a settle that never ends still trips it.
   localparam int unsigned SETTLE_MAX = PWR_LARGE_CYC + FREQ_CHANGE_CYCLES;
   logic [31:0] settle_cnt_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn || power_settled) settle_cnt_ff <= 32'h0000_0000;
      else settle_cnt_ff <= settle_cnt_ff + 32'h0000_0001;
   end
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_launch;
      burst_start && minislot_tick && !tx_active;
   endsequence
   sequence s_in_burst;
      tx_active [*2];
   endsequence
   a_start_on_tick: assert property (burst_start |-> s_launch)
      else $error("Burst start away from a mini-slot tick");
   a_start_then_active: assert property (s_launch |=> tx_active)
      else $error("Burst start without transmit");
   a_active_has_start: assert property ($rose(tx_active) |-> $past(burst_start))
      else $error("Transmit began without a burst start");
   a_power_steady: assert property (s_in_burst |-> $stable(tx_power_dbmv))
      else $error("Power moved inside a burst");
   a_cfg_steady: assert property (s_in_burst |-> $stable(tx_cfg))
      else $error("Configuration moved inside a burst");
   a_change_in_gap: assert property (
      $changed(tx_power_dbmv) || $changed(tx_cfg) |-> !tx_active)
      else $error("Parameter change while transmitting");
   a_power_in_range: assert property (tx_power_dbmv >= PWR_MIN_DBMV &&
      tx_power_dbmv <= (tx_cfg.modulation == MOD_QAM16 ? PWR_MAX_QAM16_DBMV : PWR_MAX_QPSK_DBMV))
      else $error("Applied power out of range");
   a_settle_bounded: assert property (settle_cnt_ff <= SETTLE_MAX)
      else $error("Settling lasted too long");
   a_settle_outside: assert property ($fell(power_settled) |-> !tx_active)
      else $error("Settling began inside a burst");
endmodule // ubtpc_core_chk

bind ubtpc_core ubtpc_core_chk #(
   .FREQ_CHANGE_CYCLES(FREQ_CHANGE_CYCLES),
   .SYM_CYC_FAST(SYM_CYC_FAST)
) u_ubtpc_core_chk (
   .aclk(aclk), .aresetn(aresetn), .minislot_tick(minislot_tick), .burst_start(burst_start),
   .tx_active(tx_active), .tx_cfg(tx_cfg), .tx_power_dbmv(tx_power_dbmv),
   .power_settled(power_settled)
);

// >>> tb/ubtpc_headend_model.sv
// Headend timebase model: mini-slot ticks and the derived frame time.
`timescale 1ns/1ps
module ubtpc_headend_model (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Pace: high gives one tick every other cycle.
   input wire logic slow,
   // Timebase toward the modem.
   output logic minislot_tick,
   output logic [15:0] frame_time
);
   logic tick_ff;
   logic [15:0] time_ff;
   // The slow pace makes sure the modem never assumes a tick on every cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_ff <= 1'b0;
         time_ff <= 16'h0000;
      end else begin
         tick_ff <= slow ? !tick_ff : 1'b1;
         time_ff <= time_ff + {15'h0000, tick_ff};
      end
   end
   assign minislot_tick = tick_ff;
   assign frame_time = time_ff;
endmodule // ubtpc_headend_model
